// file: verilog/lcto_pkg.sv
// Purpose: Constants for the lane 0 link-training coefficient override registers.
// Assumes: Registers stand at their printed offsets on a plain register port.
// Notes:   The control and new-word bits live outside this block and arrive as inputs.
package lcto_pkg;
  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned COEF_W           = 6;
  localparam int unsigned SWING_W          = 5;
  // Register offsets.
  localparam logic [7:0]  COEF_WORDS_ADDR  = 8'hD4;
  localparam logic [7:0]  RSVD_UPPER_ADDR  = 8'hD5;
  localparam logic [7:0]  SWING_OVRD_ADDR  = 8'hD6;
  // Field positions.
  localparam int unsigned LOCAL_LSB        = 0;
  localparam int unsigned PARTNER_LSB      = 16;
  localparam int unsigned SWING_VAL_LSB    = 0;
  localparam int unsigned SWING_EN_BIT     = 5;
  // Tap subfield positions inside a coefficient word: +1, 0, -1.
  localparam int unsigned TAP_PLUS_LSB     = 4;
  localparam int unsigned TAP_ZERO_LSB     = 2;
  localparam int unsigned TAP_MINUS_LSB    = 0;
  localparam int unsigned NUM_TAPS         = 3;
  // Tap request codes.
  localparam logic [1:0]  TAP_HOLD         = 2'h0;
  localparam logic [1:0]  TAP_INC          = 2'h1;
  localparam logic [1:0]  TAP_DEC          = 2'h2;
  localparam logic [1:0]  TAP_RSVD         = 2'h3;
  // Reset values.
  localparam logic [5:0]  COEF_RST         = 6'h00;
  localparam logic [31:0] RDATA_ZERO       = 32'h0000_0000;
endpackage : lcto_pkg

// file: verilog/lcto_coef_field.sv
// Purpose: One six-bit coefficient field that mirrors hardware or holds a software word.
// Assumes: sw_ok selects which source owns the field.
// Notes:   While software owns the field the mirror is frozen, so a write is never overrun.
`timescale 1ns/10ps
module lcto_coef_field
  import lcto_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              hw_load,
  input  wire logic [COEF_W-1:0] hw_data,
  input  wire logic              sw_ok,
  input  wire logic              sw_wr,
  input  wire logic [COEF_W-1:0] sw_data,
  output logic      [COEF_W-1:0] field_r
);
  logic [COEF_W-1:0] field_nxt;

  // Software writes only land while the field is writable; otherwise hardware feeds it.
  always_comb begin
    field_nxt = field_r;
    if (sw_ok) begin
      if (sw_wr) begin
        field_nxt = sw_data;
      end
    end else if (hw_load) begin
      field_nxt = hw_data;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      field_r <= COEF_RST;
    end else begin
      field_r <= field_nxt;
    end
  end
endmodule : lcto_coef_field

// file: verilog/lcto_regs.sv
// Purpose: Lane 0 coefficient update registers and maximum-swing override.
// Assumes: Control bits (training enable, override enables, new-word bits) are inputs.
// Notes:   Read data stands one cycle after the read strobe and only then.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module lcto_regs
  import lcto_pkg::*;
#(
  parameter bit               SIM_BUILD          = 1'b0,
  parameter logic [4:0]       SWING_OVRD_SIM_RST = 5'h00,
  parameter logic [4:0]       MAX_SWING_RULE     = 5'h00,
  parameter logic [4:0]       PRESET_MAIN_TAP    = 5'h00
)(
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              training_en,
  input  wire logic              partner_coef_takeover_en,
  input  wire logic              local_rx_takeover_en,
  input  wire logic              local_new_word,
  input  wire logic              partner_new_word,
  input  wire logic [COEF_W-1:0] lt_tx_coef,
  input  wire logic [COEF_W-1:0] lt_rx_coef,
  input  wire logic              lt_rx_valid,
  output logic                   tx_coef_send_r,
  output logic      [COEF_W-1:0] tx_coef_word_r,
  output logic      [NUM_TAPS-1:0] tx_tap_inc_r,
  output logic      [NUM_TAPS-1:0] tx_tap_dec_r,
  output logic                   eq_coef_apply_r,
  output logic      [COEF_W-1:0] eq_coef_word_r,
  output logic      [SWING_W-1:0] max_swing_eff_r,
  output logic      [SWING_W-1:0] preset_main_eff_r
);
  localparam logic SWING_EN_RST = SIM_BUILD;

  logic [COEF_W-1:0]  local_coef_request_word;
  logic [COEF_W-1:0]  partner_coef_request_word;
  logic [SWING_W-1:0] swing_limit_override_value_r;
  logic               swing_limit_override_en_r;
  logic               wr_coef;
  logic               wr_swing;
  logic               send_ok;
  logic [DATA_W-1:0]  rdata_nxt;
  logic [NUM_TAPS-1:0] inc_nxt;
  logic [NUM_TAPS-1:0] dec_nxt;

  assign wr_coef  = reg_wr && (reg_addr == COEF_WORDS_ADDR);
  assign wr_swing = reg_wr && (reg_addr == SWING_OVRD_ADDR);

  // Local field mirrors the outgoing frame word until software takes it over.
  lcto_coef_field u_local (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .hw_load (1'b1),
    .hw_data (lt_tx_coef),
    .sw_ok   (partner_coef_takeover_en),
    .sw_wr   (wr_coef),
    .sw_data (reg_wdata[LOCAL_LSB +: COEF_W]),
    .field_r (local_coef_request_word)
  );

  // Partner field tracks received frames while training runs, software owns it otherwise.
  lcto_coef_field u_partner (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .hw_load (lt_rx_valid),
    .hw_data (lt_rx_coef),
    .sw_ok   (!training_en),
    .sw_wr   (wr_coef),
    .sw_data (reg_wdata[PARTNER_LSB +: COEF_W]),
    .field_r (partner_coef_request_word)
  );

  // Swing override register; enable resets by build flavour.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      swing_limit_override_value_r <= SIM_BUILD ? SWING_OVRD_SIM_RST : 5'h00;
      swing_limit_override_en_r    <= SWING_EN_RST;
    end else if (wr_swing) begin
      swing_limit_override_value_r <= reg_wdata[SWING_VAL_LSB +: SWING_W];
      swing_limit_override_en_r    <= reg_wdata[SWING_EN_BIT];
    end
  end

  // Effective limits for this lane's transmitter; software keeps the value above initial main.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      max_swing_eff_r   <= MAX_SWING_RULE;
      preset_main_eff_r <= PRESET_MAIN_TAP;
    end else begin
      max_swing_eff_r   <= swing_limit_override_en_r ? swing_limit_override_value_r
                                                     : MAX_SWING_RULE;
      preset_main_eff_r <= swing_limit_override_en_r ? swing_limit_override_value_r
                                                     : PRESET_MAIN_TAP;
    end
  end

  // A software local word is sent only on a new-word pulse under takeover.
  assign send_ok = partner_coef_takeover_en && local_new_word;

  // Split the outgoing word into per-tap increment and decrement requests.
  always_comb begin
    inc_nxt = '0;
    dec_nxt = '0;
    for (int t = 0; t < NUM_TAPS; t++) begin
      case (local_coef_request_word[2*t +: 2])
        TAP_INC:  inc_nxt[t] = 1'b1;
        TAP_DEC:  dec_nxt[t] = 1'b1;
        default:  ;                                                            // Hold, reserved.
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_coef_send_r <= 1'b0;
      tx_coef_word_r <= COEF_RST;
      tx_tap_inc_r   <= '0;
      tx_tap_dec_r   <= '0;
    end else begin
      tx_coef_send_r <= send_ok;
      tx_coef_word_r <= local_coef_request_word;
      tx_tap_inc_r   <= inc_nxt;
      tx_tap_dec_r   <= dec_nxt;
    end
  end

  // Written partner word drives the local equalizer only on its own enable and pulse.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      eq_coef_apply_r <= 1'b0;
      eq_coef_word_r  <= COEF_RST;
    end else begin
      eq_coef_apply_r <= local_rx_takeover_en && partner_new_word;
      if (local_rx_takeover_en && partner_new_word) begin
        eq_coef_word_r <= partner_coef_request_word;
      end
    end
  end

  // Read mux; unmapped and reserved offsets read zero.
  always_comb begin
    rdata_nxt = RDATA_ZERO;
    case (reg_addr)
      COEF_WORDS_ADDR: begin
        rdata_nxt[LOCAL_LSB +: COEF_W]   = local_coef_request_word;
        rdata_nxt[PARTNER_LSB +: COEF_W] = partner_coef_request_word;
      end
      SWING_OVRD_ADDR: begin
        rdata_nxt[SWING_VAL_LSB +: SWING_W] = swing_limit_override_value_r;
        rdata_nxt[SWING_EN_BIT]             = swing_limit_override_en_r;
      end
      default: rdata_nxt = RDATA_ZERO;
    endcase
  end

  // Data stands only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= RDATA_ZERO;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : RDATA_ZERO;
    end
  end
endmodule : lcto_regs

// file: sim/lcto_regs_props.sv
// Purpose: Port assertions for the lane 0 coefficient register block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Field contents are judged through their registered copies.
`timescale 1ns/10ps
module lcto_props
  import lcto_pkg::*;
#(
  parameter logic [4:0] MAX_SWING_RULE  = 5'h00,
  parameter logic [4:0] PRESET_MAIN_TAP = 5'h00
)(
  input wire logic mclk, arst_n, reg_wr, partner_coef_takeover_en, local_rx_takeover_en,
  input wire logic local_new_word, partner_new_word, tx_coef_send_r, eq_coef_apply_r,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [COEF_W-1:0] lt_tx_coef, tx_coef_word_r,
  input wire logic [NUM_TAPS-1:0] tx_tap_inc_r, tx_tap_dec_r,
  input wire logic [SWING_W-1:0] max_swing_eff_r, preset_main_eff_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Per-tap decode of one coefficient word; the reserved code matches neither.
  function automatic logic [2:0] taps(logic [5:0] w, logic [1:0] c);
    return {w[5:4] == c, w[3:2] == c, w[1:0] == c};
  endfunction : taps
  sequence s_swing_wr;
    reg_wr && reg_addr == SWING_OVRD_ADDR;
  endsequence
  a_send_pulse: assert property (local_new_word && partner_coef_takeover_en |=> tx_coef_send_r)
    else $error("send pulse missing");
  a_send_blocked: assert property (!(local_new_word && partner_coef_takeover_en) |=> !tx_coef_send_r)
    else $error("send without takeover");
  a_apply_pulse: assert property (partner_new_word && local_rx_takeover_en |=> eq_coef_apply_r)
    else $error("apply pulse missing");
  a_apply_blocked: assert property (!(partner_new_word && local_rx_takeover_en) |=> !eq_coef_apply_r)
    else $error("apply without override enable");
  a_local_mirror: assert property (!partner_coef_takeover_en |-> ##2 tx_coef_word_r == $past(lt_tx_coef, 2))
    else $error("local field does not mirror");
  a_tap_inc: assert property (tx_tap_inc_r == taps(tx_coef_word_r, TAP_INC))
    else $error("increment decode wrong");
  a_tap_dec: assert property (tx_tap_dec_r == taps(tx_coef_word_r, TAP_DEC))
    else $error("decrement decode wrong");
  a_swing_on: assert property (s_swing_wr ##0 reg_wdata[5] |-> ##2 max_swing_eff_r == $past(reg_wdata[4:0], 2))
    else $error("swing override not applied");
  a_preset_main: assert property (s_swing_wr ##0 reg_wdata[5] |-> ##2 preset_main_eff_r == $past(reg_wdata[4:0], 2))
    else $error("preset main not replaced");
  a_swing_off: assert property (s_swing_wr ##0 !reg_wdata[5] |-> ##2 max_swing_eff_r == MAX_SWING_RULE && preset_main_eff_r == PRESET_MAIN_TAP)
    else $error("swing rule not restored");
endmodule : lcto_props
bind lcto_regs lcto_props #(.MAX_SWING_RULE(MAX_SWING_RULE), .PRESET_MAIN_TAP(PRESET_MAIN_TAP))
  lcto_props_inst (.mclk, .arst_n, .reg_wr, .partner_coef_takeover_en, .local_rx_takeover_en,
  .local_new_word, .partner_new_word, .tx_coef_send_r, .eq_coef_apply_r, .reg_addr, .reg_wdata,
  .lt_tx_coef, .tx_coef_word_r, .tx_tap_inc_r, .tx_tap_dec_r, .max_swing_eff_r, .preset_main_eff_r);

// file: sim/lcto_partner.sv
// Purpose: Remote partner sending one training frame word every eight cycles.
// Assumes: run high lets frames flow.
// Notes:   Between frames the word lines show the inverse, so stale data is caught.
`timescale 1ns/10ps
module lcto_partner
  import lcto_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              run,
  output logic      [COEF_W-1:0] lt_rx_coef,
  output logic                   lt_rx_valid
);
  logic [2:0]        cnt_r;
  logic [COEF_W-1:0] word_r;
  // Words are built from legal tap codes only, never the reserved one.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r       <= 3'h0;
      word_r      <= 6'h19;
      lt_rx_valid <= 1'b0;
    end else begin
      cnt_r       <= cnt_r + 3'h1;
      lt_rx_valid <= run && cnt_r == 3'h7;
      if (lt_rx_valid) word_r <= {word_r[3:0], (word_r[1:0] == TAP_INC) ? TAP_DEC : TAP_INC};
    end
  end
  assign lt_rx_coef = lt_rx_valid ? word_r : ~word_r;
endmodule : lcto_partner

// file: sim/link_training_coef_override_test.sv
// Purpose: Self-checking bench for the coefficient register block.
// Assumes: Simulation build with small rule parameters.
// Notes:   Read results are queued by the driver and compared by a monitor.
`timescale 1ns/10ps
module link_training_coef_override_test;
  import lcto_pkg::*;
  localparam logic [4:0] MSR = 5'h0A, PMT = 5'h07;
  logic mclk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b1, pend = 1'b0;
  logic training_en = 1'b1, partner_coef_takeover_en = 1'b0, local_rx_takeover_en = 1'b0;
  logic local_new_word = 1'b0, partner_new_word = 1'b0, lt_rx_valid, tx_coef_send_r, eq_coef_apply_r;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, expq[$];
  logic [5:0] lt_tx_coef = 6'h19, lt_rx_coef, lp = 6'h00, tx_coef_word_r, eq_coef_word_r;
  logic [2:0] tx_tap_inc_r, tx_tap_dec_r;
  logic [4:0] max_swing_eff_r, preset_main_eff_r, v;
  int failures = 0, num_checks = 0, cyc = 0, seed = 32'h34DE278D;
  always #4 mclk = ~mclk;
  lcto_regs #(.SIM_BUILD(1'b1), .SWING_OVRD_SIM_RST(5'h03), .MAX_SWING_RULE(MSR),
    .PRESET_MAIN_TAP(PMT)) lcto_regs_inst (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .training_en, .partner_coef_takeover_en, .local_rx_takeover_en,
    .local_new_word, .partner_new_word, .lt_tx_coef, .lt_rx_coef, .lt_rx_valid, .tx_coef_send_r,
    .tx_coef_word_r, .tx_tap_inc_r, .tx_tap_dec_r, .eq_coef_apply_r, .eq_coef_word_r,
    .max_swing_eff_r, .preset_main_eff_r);
  lcto_partner lcto_partner_inst (.mclk, .arst_n, .run, .lt_rx_coef, .lt_rx_valid);
  task automatic check(string n, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic finish_test();
    $display("failures=%0d num_checks=%0d", failures, num_checks);
    if (failures == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  // A gap cycle after each strobe keeps one assignment per signal per step.
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk) reg_wr <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    expq.push_back(e); reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk) reg_rd <= 1'b0;
    @(posedge mclk);
  endtask : rd
  // Read data stand only in the cycle after the strobe, so compare there.
  always @(posedge mclk) begin
    if (pend) check("rdata", reg_rdata, expq.pop_front());
    pend <= reg_rd;
    if (lt_rx_valid) lp <= lt_rx_coef;
    cyc++;
    if (cyc == 2000) begin failures++; finish_test(); end
  end
  initial begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (20) @(posedge mclk);
    run <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(8'hD6, {26'h0, 1'b1, 5'h03});
    rd(8'hD5, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'hD4, {10'h0, lp, 10'h0, 6'h19});
    wr(8'hD4, 32'h002A_0026);
    rd(8'hD4, {10'h0, lp, 10'h0, 6'h19});
    partner_coef_takeover_en <= 1'b1;
    wr(8'hD4, 32'h0000_0026);
    rd(8'hD4, {10'h0, lp, 10'h0, 6'h26});
    local_new_word <= 1'b1;
    @(posedge mclk) local_new_word <= 1'b0;
    @(posedge mclk) check("send", tx_coef_send_r, 1);
    check("tx_word", tx_coef_word_r, 6'h26);
    partner_coef_takeover_en <= 1'b0;
    local_new_word <= 1'b1;
    @(posedge mclk) local_new_word <= 1'b0;
    @(posedge mclk) check("nosend", tx_coef_send_r, 0);
    training_en <= 1'b0; lt_tx_coef <= 6'h06;
    wr(8'hD4, 32'h002A_0000);
    rd(8'hD4, {10'h0, 6'h2A, 10'h0, 6'h06});
    local_rx_takeover_en <= 1'b1; partner_new_word <= 1'b1;
    @(posedge mclk) partner_new_word <= 1'b0;
    @(posedge mclk) check("apply", eq_coef_apply_r, 1);
    check("eq_word", eq_coef_word_r, 6'h2A);
    // Override values stay above the initial main tap, so the top bit is set.
    for (int i = 0; i < 6; i++) begin
      v = {1'b1, 4'($random(seed))};
      wr(8'hD6, {26'h0, i[0], v});
      rd(8'hD6, {26'h0, i[0], v});
      check("max_swing", max_swing_eff_r, i[0] ? v : MSR);
      check("preset_main", preset_main_eff_r, i[0] ? v : PMT);
    end
    finish_test();
  end
endmodule : link_training_coef_override_test
